/* swc_pkg.sv */
// Constants, types and field layout of the sleep and wake controller
package swc_pkg;

	// ------------------------------------------------------------
	// Register offsets and fields
	// ------------------------------------------------------------
	localparam logic [13:0] ADDR_WDT_CTRL   = 14'h0018;
	localparam logic [13:0] ADDR_OPTION     = 14'h0081;
	localparam logic [13:0] ADDR_FUSE       = 14'h2007;
	localparam logic [13:0] ADDR_STATUS     = 14'h0003;
	localparam int          WDT_SWEN_BIT    = 0;
	localparam int          WDT_PS_LSB      = 1;
	localparam int          WDT_PS_MSB      = 4;
	localparam logic [7:0]  WDT_CTRL_RESET  = 8'h08;
	localparam logic [7:0]  WDT_CTRL_MASK   = 8'h1F;
	localparam logic [7:0]  OPTION_RESET    = 8'hFF;
	localparam logic [7:0]  FUSE_RESET      = 8'hFF;
	localparam int          FUSE_CPD_BIT    = 7;
	localparam int          FUSE_CP_BIT     = 6;
	localparam int          FUSE_MCLRE_BIT  = 5;
	localparam int          FUSE_FUSE_WATCHDOG_ENABLE_BIT   = 3;
	localparam int          FUSE_FOSC_MSB   = 2;
	localparam logic [2:0]  FOSC_LP         = 3'h0;
	localparam logic [2:0]  FOSC_XT         = 3'h1;
	localparam logic [2:0]  FOSC_HS         = 3'h2;
	localparam int          STATUS_PD_BIT   = 3;
	localparam int          STATUS_TO_BIT   = 4;
	localparam logic [3:0]  WDT_PS_MAX      = 4'hB;
	localparam logic [16:0] WDT_RATIO_MIN   = 17'h00020;
	localparam logic [16:0] WDT_RATIO_TOP   = 17'h10000;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int          CLK_PERIOD_NS   = 50;
	localparam int          TOSC_NS         = 50;
	localparam int          OST_TOSC        = 1024;
	localparam int          OST_CYCLES      = (OST_TOSC * TOSC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [9:0]  OST_LAST        = 10'(OST_CYCLES - 1);

	// ------------------------------------------------------------
	// Serial programming
	// ------------------------------------------------------------
	localparam logic [3:0]  CMD_LAST_BIT    = 4'h5;
	localparam logic [3:0]  DATA_LAST_BIT   = 4'hD;
	localparam logic [13:0] PC_RESET        = 14'h0000;
	localparam logic [13:0] ID_BASE         = 14'h2000;
	localparam logic [13:0] ID_TOP          = 14'h2003;
	localparam logic [5:0]  CMD_LOAD_CFG    = 6'h00;
	localparam logic [5:0]  CMD_LOAD_DATA   = 6'h02;
	localparam logic [5:0]  CMD_READ_DATA   = 6'h04;
	localparam logic [5:0]  CMD_INC_ADDR    = 6'h06;
	localparam logic [5:0]  CMD_BULK_ERASE  = 6'h09;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		S_RUN   = 2'b00,
		S_SLEEP = 2'b01,
		S_OST   = 2'b11,
		S_WAKE  = 2'b10
	} swc_state_e;

	typedef enum logic [1:0] {
		P_CMD  = 2'b00,
		P_DIN  = 2'b01,
		P_DOUT = 2'b10
	} swc_prog_e;

	typedef struct packed {
		logic second_timer_async;
		logic serial_rx;
		logic ultra_low_power_wake;
		logic adc_rc;
		logic eeprom_write;
		logic comparator;
		logic port_change;
		logic ext_int;
	} swc_wake_src_s;

	typedef struct packed {
		logic [13:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} swc_bus_req_s;

endpackage

/* swc_sleep_wake.sv */
// Sleep, wake, watchdog and serial program mode controller
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
module swc_sleep_wake (
	// Clock, reset, enable
	input  wire logic                   clk_sys,
	input  wire logic                   rst,
	input  wire logic                   clk_en,
	// Register port
	input  wire swc_pkg::swc_bus_req_s  bus_req,
	output logic [7:0]                  bus_rdata,
	// Core
	input  wire logic                   sleep_instr,
	input  wire logic                   watchdog_clear_instr,
	input  wire logic                   global_irq_enable,
	input  wire swc_pkg::swc_wake_src_s irq_flag,
	input  wire swc_pkg::swc_wake_src_s irq_enable,
	input  wire logic                   wdt_tick,
	output logic                        core_run,
	output logic                        osc_drive_en,
	output logic                        port_hold,
	output logic                        prefetch_next,
	output logic                        resume_pulse,
	output logic                        vector_req,
	output logic                        core_reset,
	output logic                        wdt_reset,
	output logic                        powerdown_flag,
	output logic                        timeout_flag,
	// Master clear pin
	input  wire logic                   master_clear_pin,
	input  wire logic                   master_clear_hv,
	output logic                        master_clear_out,
	output logic                        master_clear_oe,
	// Programming pins
	input  wire logic                   prog_data_pin,
	input  wire logic                   prog_clock_pin,
	output logic                        prog_data_out,
	output logic                        prog_data_oe,
	output logic                        prog_mode,
	// Program memory
	input  wire logic [13:0]            flash_rdata,
	output logic [13:0]                 flash_addr,
	output logic [13:0]                 flash_wdata,
	output logic                        flash_wr,
	output logic                        flash_erase,
	output logic                        eeprom_erase
);
	import swc_pkg::*;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	swc_state_e  state;
	swc_state_e  next_state;
	swc_prog_e   pstate;
	logic [7:0]  wdt_ctrl;
	logic [7:0]  option_reg;
	logic [7:0]  fuse;
	logic [16:0] wdt_count;
	logic [9:0]  ost_cnt;
	logic        wake_by_irq;
	logic        pending;
	logic        ext_rst;
	logic        crystal;
	logic        sleep_go;
	logic        wdt_en;
	logic        wdt_expire;
	logic        wdt_clear;
	logic        leave_sleep;
	logic        prog_clk_q;
	logic        prog_fall;
	logic        prog_rise;
	logic [3:0]  bit_cnt;
	logic [5:0]  cmd_sh;
	logic [5:0]  cmd_now;
	logic [13:0] din_sh;
	logic [13:0] din_now;
	logic [13:0] dout_sh;
	logic [13:0] pc;
	logic        din_done;
	logic [13:0] din_word;
	logic        erase_cmd;
	logic [6:0]  id_mem [4];

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [16:0] wdt_ratio(input logic [3:0] ps);
		if (ps <= WDT_PS_MAX) begin
			wdt_ratio = WDT_RATIO_MIN << ps;
		end else begin
			wdt_ratio = WDT_RATIO_TOP;
		end
	endfunction

	function automatic logic in_id(input logic [13:0] a);
		in_id = (a >= ID_BASE) && (a <= ID_TOP);
	endfunction

	// ------------------------------------------------------------
	// Wake and sleep decode
	// ------------------------------------------------------------
	assign pending     = |(8'(irq_flag) & 8'(irq_enable));
	assign ext_rst     = !master_clear_pin && fuse[FUSE_MCLRE_BIT] && !prog_mode;
	assign crystal     = fuse[FUSE_FOSC_MSB:0] inside {FOSC_LP, FOSC_XT, FOSC_HS};
	assign sleep_go    = (state == S_RUN) && sleep_instr && !pending && !prog_mode && !ext_rst;
	assign wdt_en      = fuse[FUSE_FUSE_WATCHDOG_ENABLE_BIT] || wdt_ctrl[WDT_SWEN_BIT];
	assign wdt_expire  = wdt_en && wdt_tick && (state != S_OST)
		&& (wdt_count >= wdt_ratio(wdt_ctrl[WDT_PS_MSB:WDT_PS_LSB]) - 17'h00001);
	assign leave_sleep = (state == S_SLEEP) && (pending || wdt_expire);
	assign wdt_clear   = watchdog_clear_instr || sleep_go || leave_sleep || (state == S_OST) || ext_rst || !wdt_en;

	always_comb begin
		next_state = state;
		case (state)
			S_RUN: begin
				if (sleep_go) begin
					next_state = S_SLEEP;
				end
			end
			S_SLEEP: begin
				if (leave_sleep) begin
					next_state = crystal ? S_OST : S_WAKE;
				end
			end
			S_OST: begin
				if (ost_cnt == OST_LAST) begin
					next_state = S_WAKE;
				end
			end
			default: begin
				next_state = S_RUN;
			end
		endcase
		if (ext_rst) begin
			next_state = S_RUN;
		end
	end

	// ------------------------------------------------------------
	// Power state
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state <= S_RUN;
		end else if (clk_en) begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ost_cnt <= '0;
		end else if (clk_en) begin
			ost_cnt <= (state == S_OST) ? ost_cnt + 10'h001 : 10'h000;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wake_by_irq <= 1'b0;
		end else if (clk_en && leave_sleep) begin
			wake_by_irq <= pending;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			core_run      <= 1'b1;
			osc_drive_en  <= 1'b1;
			port_hold     <= 1'b0;
			prefetch_next <= 1'b0;
			resume_pulse  <= 1'b0;
			vector_req    <= 1'b0;
			core_reset    <= 1'b0;
			wdt_reset     <= 1'b0;
		end else if (clk_en) begin
			core_run      <= (next_state == S_RUN) && !prog_mode;
			osc_drive_en  <= (next_state != S_SLEEP);
			port_hold     <= (next_state == S_SLEEP) || (next_state == S_OST);
			prefetch_next <= (state == S_RUN) && sleep_instr;
			resume_pulse  <= (state == S_WAKE) && !ext_rst;
			vector_req    <= (state == S_WAKE) && !ext_rst && wake_by_irq && global_irq_enable;
			core_reset    <= ext_rst;
			wdt_reset     <= wdt_expire && (state == S_RUN);
		end
	end

	// Master clear is input only
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			master_clear_out <= 1'b0;
			master_clear_oe  <= 1'b0;
		end else if (clk_en) begin
			master_clear_out <= 1'b0;
			master_clear_oe  <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Status flags
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			powerdown_flag <= 1'b1;
			timeout_flag   <= 1'b1;
		end else if (clk_en) begin
			if (wdt_expire) begin
				timeout_flag <= 1'b0;
			end else if (sleep_go) begin
				powerdown_flag <= 1'b0;
				timeout_flag   <= 1'b1;
			end else if (watchdog_clear_instr) begin
				powerdown_flag <= 1'b1;
				timeout_flag   <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Watchdog counter
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wdt_count <= '0;
		end else if (clk_en) begin
			if (wdt_clear || wdt_expire) begin
				wdt_count <= '0;
			end else if (wdt_tick) begin
				wdt_count <= wdt_count + 17'h00001;
			end
		end
	end

	// ------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wdt_ctrl   <= WDT_CTRL_RESET;
			option_reg <= OPTION_RESET;
		end else if (clk_en && bus_req.wr) begin
			if (bus_req.addr == ADDR_WDT_CTRL) begin
				wdt_ctrl <= bus_req.wdata & WDT_CTRL_MASK;
			end else if (bus_req.addr == ADDR_OPTION) begin
				option_reg <= bus_req.wdata;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bus_rdata <= '0;
		end else if (clk_en) begin
			if (!bus_req.rd) begin
				bus_rdata <= '0;
			end else if (bus_req.addr == ADDR_WDT_CTRL) begin
				bus_rdata <= wdt_ctrl;
			end else if (bus_req.addr == ADDR_OPTION) begin
				bus_rdata <= option_reg;
			end else if (bus_req.addr == ADDR_FUSE) begin
				bus_rdata <= fuse;
			end else if (bus_req.addr == ADDR_STATUS) begin
				bus_rdata <= 8'(({1'b0, timeout_flag, powerdown_flag}) << STATUS_PD_BIT);
			end else begin
				bus_rdata <= '0;
			end
		end
	end

	// ------------------------------------------------------------
	// Serial program and verify
	// ------------------------------------------------------------
	assign prog_fall = prog_clk_q && !prog_clock_pin;
	assign prog_rise = !prog_clk_q && prog_clock_pin;
	assign cmd_now   = {prog_data_pin, cmd_sh[5:1]};
	assign din_now   = {prog_data_pin, din_sh[13:1]};

	function automatic logic [13:0] read_word(input logic [13:0] a);
		if (in_id(a)) begin
			read_word = {7'h00, id_mem[a[1:0]]};
		end else if (a == ADDR_FUSE) begin
			read_word = {6'h00, fuse};
		end else if (fuse[FUSE_CP_BIT]) begin
			read_word = flash_rdata;
		end else begin
			read_word = '0;
		end
	endfunction

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prog_clk_q <= 1'b0;
		end else if (clk_en) begin
			prog_clk_q <= prog_clock_pin;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prog_mode <= 1'b0;
			pstate    <= P_CMD;
			bit_cnt   <= '0;
			cmd_sh    <= '0;
			din_sh    <= '0;
			dout_sh   <= '0;
			pc        <= PC_RESET;
			din_done  <= 1'b0;
			din_word  <= '0;
			erase_cmd <= 1'b0;
		end else if (clk_en) begin
			din_done  <= 1'b0;
			erase_cmd <= 1'b0;
			if (!master_clear_hv) begin
				prog_mode <= 1'b0;
			end else if (!prog_mode) begin
				if (!prog_data_pin && !prog_clock_pin) begin
					prog_mode <= 1'b1;
					pstate    <= P_CMD;
					bit_cnt   <= '0;
					pc        <= PC_RESET;
				end
			end else if (prog_rise && pstate == P_DOUT) begin
				dout_sh <= {1'b0, dout_sh[13:1]};
			end else if (prog_fall) begin
				bit_cnt <= bit_cnt + 4'h1;
				case (pstate)
					P_CMD: begin
						cmd_sh <= cmd_now;
						if (bit_cnt == CMD_LAST_BIT) begin
							bit_cnt <= '0;
							if (cmd_now == CMD_LOAD_CFG) begin
								pc     <= ID_BASE;
								pstate <= P_DIN;
							end else if (cmd_now == CMD_LOAD_DATA) begin
								pstate <= P_DIN;
							end else if (cmd_now == CMD_READ_DATA) begin
								pstate  <= P_DOUT;
								dout_sh <= read_word(pc);
							end else if (cmd_now == CMD_INC_ADDR) begin
								pc <= pc + 14'h0001;
							end else if (cmd_now == CMD_BULK_ERASE) begin
								erase_cmd <= 1'b1;
							end
						end
					end
					P_DIN: begin
						din_sh <= din_now;
						if (bit_cnt == DATA_LAST_BIT) begin
							bit_cnt  <= '0;
							din_done <= 1'b1;
							din_word <= din_now;
							pstate   <= P_CMD;
						end
					end
					default: begin
						if (bit_cnt == DATA_LAST_BIT) begin
							bit_cnt <= '0;
							pstate  <= P_CMD;
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prog_data_out <= 1'b0;
			prog_data_oe  <= 1'b0;
		end else if (clk_en) begin
			prog_data_oe <= prog_mode && (pstate == P_DOUT);
			if (prog_rise && pstate == P_DOUT) begin
				prog_data_out <= dout_sh[0];
			end
		end
	end

	// ------------------------------------------------------------
	// ID words, fuses and memory writes
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			fuse         <= FUSE_RESET;
			flash_wr     <= 1'b0;
			flash_erase  <= 1'b0;
			eeprom_erase <= 1'b0;
			flash_addr   <= '0;
			flash_wdata  <= '0;
			for (int i = 0; i < 4; i++) begin
				id_mem[i] <= '0;
			end
		end else if (clk_en) begin
			flash_wr     <= 1'b0;
			flash_erase  <= erase_cmd;
			eeprom_erase <= erase_cmd;
			flash_addr   <= pc;
			if (din_done) begin
				if (in_id(pc)) begin
					id_mem[pc[1:0]] <= din_word[6:0];
				end else if (pc == ADDR_FUSE) begin
					fuse <= din_word[7:0];
					if ((!fuse[FUSE_CP_BIT] && din_word[FUSE_CP_BIT])
						|| (!fuse[FUSE_CPD_BIT] && din_word[FUSE_CPD_BIT])) begin
						flash_erase  <= 1'b1;
						eeprom_erase <= 1'b1;
					end
				end else begin
					flash_wr    <= 1'b1;
					flash_wdata <= din_word;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst || !clk_en);

	sequence seq_sleep_enter;
		sleep_go ##1 (state == S_SLEEP);
	endsequence

	sequence seq_wake_exit;
		(state == S_SLEEP) ##1 (state != S_SLEEP);
	endsequence

	a_sleep_entry: assert property (sleep_go |=> state == S_SLEEP && !osc_drive_en)
		else $error("sleep not entered");
	a_entry_flags: assert property (sleep_go && !wdt_expire |=> !powerdown_flag && timeout_flag)
		else $error("entry flags wrong");
	a_port_hold: assert property ((state == S_SLEEP) |-> port_hold && !core_run)
		else $error("ports not held");
	a_master_clear_pin_quiet: assert property (wdt_reset |-> !master_clear_oe)
		else $error("watchdog drives master clear");
	a_wdt_wake_flag: assert property (leave_sleep && !pending |=> !timeout_flag)
		else $error("watchdog wake flag");
	a_nop_sleep: assert property ((state == S_RUN) && sleep_instr && pending && !ext_rst
		|=> state == S_RUN && $stable(powerdown_flag))
		else $error("pending sleep not a no-op");
	a_wdt_cleared: assert property (seq_sleep_enter |-> wdt_count <= 17'h00001)
		else $error("watchdog not cleared on entry");
	a_wake_clear: assert property (seq_wake_exit |-> wdt_count == 17'h00000)
		else $error("watchdog not cleared on wake");
	a_ost_wait: assert property ($changed(state) && state == S_OST && !ext_rst |-> (state == S_OST)[*8])
		else $error("start-up delay cut short");
	a_rc_skip: assert property (leave_sleep && !crystal && !ext_rst |=> state == S_WAKE)
		else $error("start-up delay not skipped");
	a_irq_vector: assert property ((state == S_WAKE) && !ext_rst
		|=> resume_pulse && (vector_req == ($past(wake_by_irq) && $past(global_irq_enable))))
		else $error("wake vector wrong");
	a_ext_reset: assert property (ext_rst |=> core_reset && state == S_RUN)
		else $error("external reset not full");
	a_irq_wake: assert property ((state == S_SLEEP) && pending && !ext_rst |=> state != S_SLEEP)
		else $error("interrupt did not wake");

endmodule

/* swc_programmer.sv */
// Behavioural serial programmer on the program mode pins
`timescale 1ns/1ps
module swc_programmer (
	// Clock
	input  wire logic clk_sys,
	// Pins
	input  wire logic pin_in,
	output logic      hv,
	output logic      data_drv,
	output logic      clk_out
);
	initial begin
		hv = 1'b0;
		data_drv = 1'b0;
		clk_out = 1'b0;
	end

	// Raise programming voltage with data and clock low
	task automatic enter();
		@(posedge clk_sys);
		data_drv <= 1'b0;
		clk_out <= 1'b0;
		hv <= 1'b1;
		repeat (4) @(posedge clk_sys);
	endtask

	// Shift n bits LSB first; in read phase data toggles, not released
	task automatic shift(input int n, input logic [13:0] v, input logic rd, output logic [13:0] got);
		got = '0;
		for (int i = 0; i < n; i++) begin
			@(posedge clk_sys);
			clk_out <= 1'b1;
			data_drv <= rd ? ~data_drv : v[i];
			repeat (3) @(posedge clk_sys);
			got[i] = pin_in;
			clk_out <= 1'b0;
			repeat (3) @(posedge clk_sys);
		end
	endtask

	// Command, then a data word to or from the device
	task automatic xfer(input logic [5:0] cmd, input logic [13:0] v, input logic rd, output logic [13:0] got);
		shift(6, {8'h00, cmd}, 1'b0, got);
		shift(14, v, rd, got);
	endtask

	// Drop programming voltage and let the mode end
	task automatic leave();
		@(posedge clk_sys);
		hv <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask
endmodule

/* swc_sleep_wake_bench.sv */
// Self-checking bench for the sleep and wake controller
`timescale 1ns/1ps
module swc_sleep_wake_bench;
	import swc_pkg::*;
	logic clk_sys, rst, clk_en, sleep_instr, watchdog_clear_instr, global_irq_enable, wdt_tick;
	logic core_run, osc_drive_en, port_hold, prefetch_next, resume_pulse, vector_req, core_reset;
	logic wdt_reset, powerdown_flag, timeout_flag, master_clear_pin, master_clear_hv;
	logic master_clear_out, master_clear_oe, prog_data_pin, prog_clock_pin, prog_data_out;
	logic prog_data_oe, prog_mode, flash_wr, flash_erase, eeprom_erase, data_drv;
	logic [7:0]    bus_rdata, rv;
	logic [13:0]   flash_rdata, flash_addr, flash_wdata, got;
	swc_bus_req_s  bus_req;
	swc_wake_src_s irq_flag, irq_enable;
	int            failures = 0;
	int            n_checks = 0;
	int            cycles = 0;
	logic          erase_seen = 1'b0;

	assign prog_data_pin = prog_data_oe ? prog_data_out : data_drv;
	assign flash_rdata = flash_addr ^ 14'h2A5A;
	always @(posedge clk_sys) begin
		if (flash_erase && eeprom_erase) begin
			erase_seen <= 1'b1;
		end
	end

	swc_sleep_wake swc_sleep_wake_i (.clk_sys, .rst, .clk_en, .bus_req, .bus_rdata, .sleep_instr,
		.watchdog_clear_instr, .global_irq_enable, .irq_flag, .irq_enable, .wdt_tick, .core_run,
		.osc_drive_en, .port_hold, .prefetch_next, .resume_pulse, .vector_req, .core_reset, .wdt_reset,
		.powerdown_flag, .timeout_flag, .master_clear_pin, .master_clear_hv, .master_clear_out,
		.master_clear_oe, .prog_data_pin, .prog_clock_pin, .prog_data_out, .prog_data_oe, .prog_mode,
		.flash_rdata, .flash_addr, .flash_wdata, .flash_wr, .flash_erase, .eeprom_erase);
	swc_programmer swc_programmer_i (.clk_sys, .pin_in(prog_data_pin), .hv(master_clear_hv),
		.data_drv, .clk_out(prog_clock_pin));

	// ------------------------------------------------------------
	// Clock, watchdog of the run, reporting
	// ------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures = failures + 1;
			conclude();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Bus and core helpers
	// ------------------------------------------------------------
	task automatic wr(input logic [13:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		bus_req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [13:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		bus_req.rd <= 1'b0;
		@(posedge clk_sys);
		d = bus_rdata;
	endtask
	task automatic doze();
		@(posedge clk_sys);
		sleep_instr <= 1'b1;
		@(posedge clk_sys);
		sleep_instr <= 1'b0;
		#1;
		check(prefetch_next, 1'b1);
	endtask
	task automatic await_resume(input int lim);
		int k;
		k = 0;
		while (resume_pulse !== 1'b1 && k < lim) begin
			@(posedge clk_sys);
			#1;
			k++;
		end
		check(resume_pulse, 1'b1);
		check(core_reset, 1'b0);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		rd(ADDR_WDT_CTRL, rv);
		check(rv, 8'h08);
		wr(ADDR_FUSE, 8'h00);
		rd(ADDR_FUSE, rv);
		check(rv, 8'hFF);
		wr(ADDR_WDT_CTRL, 8'hFF);
		rd(ADDR_WDT_CTRL, rv);
		check(rv, 8'h1F);
		wr(ADDR_WDT_CTRL, 8'h00);
		rd(ADDR_WDT_CTRL, rv);
		check(rv, 8'h00);
		rd(ID_TOP, rv);
		check(rv, 8'h00);
	endtask
	task automatic t_pending();
		@(posedge clk_sys);
		watchdog_clear_instr <= 1'b1;
		irq_flag <= 8'h01;
		irq_enable <= 8'h01;
		@(posedge clk_sys);
		watchdog_clear_instr <= 1'b0;
		doze();
		check({osc_drive_en, powerdown_flag}, 2'b11);
		@(posedge clk_sys);
		irq_flag <= '0;
		irq_enable <= '0;
	endtask
	task automatic t_wake();
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_sys);
			global_irq_enable <= i[0];
			irq_flag <= swc_wake_src_s'(8'(1 << i));
			doze();
			check({osc_drive_en, port_hold, core_run}, 3'b010);
			check({powerdown_flag, timeout_flag}, 2'b01);
			repeat (5) @(posedge clk_sys);
			#1;
			check(core_run, 1'b0);
			@(posedge clk_sys);
			irq_enable <= swc_wake_src_s'(8'(1 << i));
			await_resume(20);
			check(vector_req, i[0]);
			@(posedge clk_sys);
			irq_flag <= '0;
			irq_enable <= '0;
		end
	endtask
	task automatic t_wdt();
		doze();
		@(posedge clk_sys);
		wdt_tick <= 1'b1;
		await_resume(100);
		check(timeout_flag, 1'b0);
		check(master_clear_oe, 1'b0);
		for (int j = 0; j < 40 && wdt_reset !== 1'b1; j++) begin
			@(posedge clk_sys);
			#1;
		end
		check(wdt_reset, 1'b1);
		check(master_clear_oe, 1'b0);
		@(posedge clk_sys);
		wdt_tick <= 1'b0;
	endtask
	task automatic t_master_clear_pin();
		doze();
		@(posedge clk_sys);
		master_clear_pin <= 1'b0;
		repeat (3) @(posedge clk_sys);
		#1;
		check(core_reset, 1'b1);
		@(posedge clk_sys);
		master_clear_pin <= 1'b1;
		repeat (4) @(posedge clk_sys);
	endtask
	task automatic t_prog();
		swc_programmer_i.enter();
		check(prog_mode, 1'b1);
		swc_programmer_i.xfer(CMD_READ_DATA, 14'h0000, 1'b1, got);
		check(got, 14'h2A5A);
		swc_programmer_i.xfer(CMD_LOAD_CFG, 14'h3FD5, 1'b0, got);
		repeat (4) @(posedge clk_sys);
		swc_programmer_i.xfer(CMD_READ_DATA, 14'h0000, 1'b1, got);
		check(got, 14'h0055);
		for (int i = 0; i < 7; i++) begin
			swc_programmer_i.shift(6, {8'h00, CMD_INC_ADDR}, 1'b0, got);
		end
		swc_programmer_i.xfer(CMD_LOAD_DATA, 14'h00B9, 1'b0, got);
		repeat (2) @(posedge clk_sys);
		check(erase_seen, 1'b0);
		swc_programmer_i.xfer(CMD_LOAD_DATA, 14'h00F9, 1'b0, got);
		swc_programmer_i.xfer(CMD_READ_DATA, 14'h0000, 1'b1, got);
		check(got, 14'h00F9);
		check(erase_seen, 1'b1);
		swc_programmer_i.leave();
		rd(ID_BASE, rv);
		check(rv, 8'h00);
		rd(ADDR_FUSE, rv);
		check(rv, 8'hF9);
	endtask
	task automatic t_ost();
		doze();
		@(posedge clk_sys);
		irq_flag <= 8'h01;
		irq_enable <= 8'h01;
		repeat (1000) @(posedge clk_sys);
		#1;
		check(core_run, 1'b0);
		await_resume(40);
		@(posedge clk_sys);
		irq_flag <= '0;
		irq_enable <= '0;
	endtask

	initial begin
		rst = 1'b1;
		clk_en = 1'b1;
		bus_req = '0;
		sleep_instr = 1'b0;
		watchdog_clear_instr = 1'b0;
		global_irq_enable = 1'b0;
		irq_flag = '0;
		irq_enable = '0;
		wdt_tick = 1'b0;
		master_clear_pin = 1'b1;
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		t_regs();
		t_pending();
		t_wake();
		t_wdt();
		t_master_clear_pin();
		t_prog();
		t_ost();
		conclude();
	end
endmodule
